// *** rtl/hbd_device.sv ***
`include "hbd_cfg.svh"
`default_nettype none
module hbd_device
   import hbd_pkg::*;
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          nrst,
   input  wire logic          clkEn,
   // Host bus
   hbd_bus_if.dev             bus,
   // Internal event sources
   input  wire logic [1:0]    irqSrc,
   // Graphics memory write stream
   output logic               gmWrValid,
   output logic [21:0]        gmWrAddr,
   output logic [15:0]        gmWrData,
   output logic [1:0]         gmWrLanes
);
   ////////////////////////////////////////////////////////////////////////////
   hbd_dev_state_type state_ff;
   logic [15:0] gmem [0:`HBD_GM_WORDS-1];
   logic [21:0] xStart_ff;
   logic [15:0] xCount_ff;
   logic [1:0]  xMode_ff;
   logic [1:0]  xAmode_ff;
   logic [2:0]  convFmt_ff;
   logic [1:0]  irqEn_ff;
   logic [1:0]  irqSts_ff;
   logic [15:0] image_ff;
   logic [21:0] xAddr_ff;
   logic [15:0] xLeft_ff;
   logic        xActive_ff;
   logic        xDone_ff;
   logic [1:0]  cnt_ff;
   logic [15:0] rdata_ff;
   logic        waitN_ff;
   logic        reqN_ff;
   logic        irqN_ff;
   logic        isMem;
   logic        isReg;
   logic        strobe;
   logic        grantHit;
   logic [9:0]  regIdx;
   logic        xCtlWr;
   assign isMem    = !bus.memorySelectN && bus.registerSelectN;
   assign isReg    = !bus.registerSelectN && bus.memorySelectN;
   assign strobe   = !bus.readN || !bus.lowLaneWriteN || !bus.highLaneWriteN;
   // Dual mode ignores memory select; single mode still needs grant only
   assign grantHit = xActive_ff && !bus.xferGrantN
                   && (xAmode_ff == `HBD_AMODE_DUAL ? 1'b1 : 1'b1);
   assign regIdx   = bus.hostAddr[10:1];
   assign xCtlWr   = state_ff == HST_STALL && isReg && !bus.lowLaneWriteN
                   && regIdx == `HBD_REG_XCTRL && cnt_ff == `HBD_WAIT_CYC;
   function automatic logic [15:0] laneMerge(input logic [15:0] old,
      input logic [15:0] nw, input logic lo, input logic hi);
      laneMerge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer: wait rises the cycle after a strobe is seen
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff <= HST_IDLE;
         cnt_ff   <= 2'h0;
         waitN_ff <= 1'b1;
      end
      else if (clkEn)
      begin
         unique case (state_ff)
            HST_IDLE:
            begin
               if (grantHit && strobe)
               begin
                  state_ff <= HST_XFER;
                  waitN_ff <= 1'b0;
               end
               else if ((isMem || isReg) && strobe)
               begin
                  state_ff <= HST_STALL;
                  cnt_ff   <= 2'h0;
                  waitN_ff <= 1'b0;
               end
            end
            HST_STALL:
            begin
               cnt_ff <= cnt_ff + 2'h1;
               if (cnt_ff == `HBD_WAIT_CYC)
               begin
                  state_ff <= HST_DONE;
                  waitN_ff <= 1'b1;
               end
            end
            HST_XFER:
            begin
               state_ff <= HST_DONE;
               waitN_ff <= 1'b1;
            end
            HST_DONE:
            begin
               // Wait for host to drop strobes so one access counts once
               if (!strobe)
                  state_ff <= HST_IDLE;
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Host register writes, image entry from transfers, read data capture
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         xStart_ff  <= 22'h0;
         xCount_ff  <= 16'h0;
         xMode_ff   <= 2'h0;
         xAmode_ff  <= 2'h0;
         convFmt_ff <= 3'h0;
         irqEn_ff   <= 2'h0;
         image_ff   <= 16'h0;
         rdata_ff   <= 16'h0;
      end
      else if (clkEn)
      begin
         if (state_ff == HST_STALL && cnt_ff == `HBD_WAIT_CYC)
         begin
            if (isReg && !bus.lowLaneWriteN && !bus.highLaneWriteN)
            begin
               unique case (regIdx)
                  `HBD_REG_XSTART: xStart_ff  <= {6'h0, bus.hostWdata};
                  `HBD_REG_XCOUNT: xCount_ff  <= bus.hostWdata;
                  `HBD_REG_XCTRL:
                  begin
                     xMode_ff  <= bus.hostWdata[1:0];
                     xAmode_ff <= bus.hostWdata[3:2];
                  end
                  `HBD_REG_IRQEN:  irqEn_ff   <= bus.hostWdata[1:0];
                  `HBD_REG_IMAGE:  image_ff   <= bus.hostWdata;
                  `HBD_REG_CONV:   convFmt_ff <= bus.hostWdata[2:0];
                  default:         image_ff   <= image_ff;
               endcase
            end
            else if (isReg && !bus.readN)
            begin
               unique case (regIdx)
                  `HBD_REG_XSTART: rdata_ff <= xStart_ff[15:0];
                  `HBD_REG_XCOUNT: rdata_ff <= xLeft_ff;
                  `HBD_REG_XCTRL:  rdata_ff <= {12'h0, xAmode_ff, xMode_ff};
                  `HBD_REG_STATUS: rdata_ff <= {14'h0, xActive_ff, xDone_ff};
                  `HBD_REG_IRQEN:  rdata_ff <= {14'h0, irqEn_ff};
                  `HBD_REG_IMAGE:  rdata_ff <= image_ff;
                  `HBD_REG_CONV:   rdata_ff <= {13'h0, convFmt_ff};
                  `HBD_REG_IRQSTS: rdata_ff <= {14'h0, irqSts_ff};
                  default:         rdata_ff <= 16'h0;
               endcase
            end
            else if (isMem && !bus.readN)
               rdata_ff <= gmem[bus.hostAddr[8:1]];
         end
         else if (state_ff == HST_XFER && xMode_ff == `HBD_MODE_IMG)
            image_ff <= bus.hostWdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Graphics memory array; only a small window is modelled on chip
   always_ff @(posedge core_clk)
   begin
      if (clkEn && gmWrValid)
         gmem[gmWrAddr[8:1]] <= laneMerge(gmem[gmWrAddr[8:1]], gmWrData,
                                          gmWrLanes[0], gmWrLanes[1]);
   end
   ////////////////////////////////////////////////////////////////////////////
   // Write stream toward memory controller
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         gmWrValid <= 1'b0;
         gmWrAddr  <= 22'h0;
         gmWrData  <= 16'h0;
         gmWrLanes <= 2'h0;
      end
      else if (clkEn)
      begin
         gmWrValid <= 1'b0;
         if (state_ff == HST_STALL && cnt_ff == `HBD_WAIT_CYC && isMem
             && (!bus.lowLaneWriteN || !bus.highLaneWriteN))
         begin
            gmWrValid <= 1'b1;
            gmWrAddr  <= {bus.hostAddr, 1'b0};
            gmWrData  <= bus.hostWdata;
            gmWrLanes <= {!bus.highLaneWriteN, !bus.lowLaneWriteN};
         end
         else if (state_ff == HST_XFER && xMode_ff == `HBD_MODE_MEM)
         begin
            gmWrValid <= 1'b1;
            gmWrAddr  <= xAddr_ff;
            gmWrData  <= bus.hostWdata;
            gmWrLanes <= 2'h3;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Transfer engine: armed by a control write, counts words down
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         xActive_ff <= 1'b0;
         xDone_ff   <= 1'b1;
         xAddr_ff   <= 22'h0;
         xLeft_ff   <= 16'h0;
         reqN_ff    <= 1'b1;
      end
      else if (clkEn)
      begin
         if (xCtlWr && bus.hostWdata[0] && xCount_ff != 16'h0)
         begin
            xActive_ff <= 1'b1;
            xDone_ff   <= 1'b0;
            xAddr_ff   <= xStart_ff;
            xLeft_ff   <= xCount_ff;
            reqN_ff    <= 1'b0;
         end
         else if (state_ff == HST_XFER)
         begin
            xAddr_ff <= xAddr_ff + 22'h2;
            xLeft_ff <= xLeft_ff - 16'h1;
            if (xLeft_ff == 16'h1)
            begin
               xActive_ff <= 1'b0;
               xDone_ff   <= 1'b1;
               reqN_ff    <= 1'b1;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Interrupt: sticky sources, cleared by reading; set beats clear
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irqSts_ff <= 2'h0;
         irqN_ff   <= 1'b1;
      end
      else if (clkEn)
      begin
         if (state_ff == HST_STALL && cnt_ff == `HBD_WAIT_CYC && isReg
             && !bus.readN && regIdx == `HBD_REG_IRQSTS)
            irqSts_ff <= irqSrc | {1'b0, state_ff == HST_XFER && xLeft_ff == 16'h1};
         else
            irqSts_ff <= irqSts_ff | irqSrc
                       | {1'b0, state_ff == HST_XFER && xLeft_ff == 16'h1};
         irqN_ff <= !(|(irqSts_ff & irqEn_ff));
      end
   end
   assign bus.waitN        = waitN_ff;
   assign bus.xferRequestN = reqN_ff;
   assign bus.irqN         = irqN_ff;
   assign bus.devRdata     = rdata_ff;
endmodule
`default_nettype wire

// *** rtl/hbd_cfg.svh ***
`ifndef HBD_CFG_SVH
`define HBD_CFG_SVH
// Overview of operation
// - Low memory select picks graphics memory, register select registers
// - Host never asserts both selects together
// - Host keeps memory addresses inside configured range
// - Address lines carry byte address, bit zero absent
// - Registers word only; memory word or byte
// - Word write both strobes; byte write one lane
// - Wait asserted within three cycles of strobe
// - Wait held at least one core cycle
// - Host bus no faster than core clock
// - Read strobe marks reads, always whole words
// - Transfer engine writes only, one word each
// - Program start, count, modes; then request, grant
// - Mode 01 memory, mode 11 image entry register
// - Address mode 00/01 single, 10 dual timing
// - Dual mode uses grant, memory select ignored
// - Internal counter addresses, exact count, bus address ignored
// - Software checks finished flag before new mode
// - Transfer host bus at most half core clock
// - Controller: falling-edge request, cycle steal, low grant
// - Interrupt sources gated by enable register bits

`define HBD_ADDR_W      22
`define HBD_DATA_W      16
`define HBD_WAIT_CYC    2'h2
`define HBD_MODE_MEM    2'h1
`define HBD_MODE_IMG    2'h3
`define HBD_AMODE_DUAL  2'h2
`define HBD_FMT_PLAIN   3'h0
// APB register byte offsets
`define HBD_APB_CTRL    12'h000
`define HBD_APB_ADDR    12'h004
`define HBD_APB_WDATA   12'h008
`define HBD_APB_RDATA   12'h00C
`define HBD_APB_STAT    12'h010
// Device register indices (word index within register window)
`define HBD_REG_XSTART  10'h000
`define HBD_REG_XCOUNT  10'h001
`define HBD_REG_XCTRL   10'h002
`define HBD_REG_STATUS  10'h003
`define HBD_REG_IRQEN   10'h004
`define HBD_REG_IMAGE   10'h005
`define HBD_REG_CONV    10'h006
`define HBD_REG_IRQSTS  10'h007
`define HBD_GM_WORDS    256
`endif

// *** rtl/hbd_pkg.sv ***
`default_nettype none
package hbd_pkg;
   typedef enum logic [3:0]
   {
      HST_IDLE  = 4'h1,
      HST_STALL = 4'h2,
      HST_DONE  = 4'h4,
      HST_XFER  = 4'h8
   } hbd_dev_state_type;
   typedef enum logic [3:0]
   {
      HBS_IDLE  = 4'h1,
      HBS_STRB  = 4'h2,
      HBS_WAIT  = 4'h4,
      HBS_REL   = 4'h8
   } hbd_host_state_type;
endpackage
`default_nettype wire

// *** rtl/hbd_bus_if.sv ***
`default_nettype none
interface hbd_bus_if;
   logic [21:1] hostAddr;
   logic [15:0] hostWdata;
   logic [15:0] devRdata;
   logic        memorySelectN;
   logic        registerSelectN;
   logic        readN;
   logic        lowLaneWriteN;
   logic        highLaneWriteN;
   logic        waitN;
   logic        xferRequestN;
   logic        xferGrantN;
   logic        irqN;
   modport dev
   (
      input  hostAddr, hostWdata, memorySelectN, registerSelectN, readN,
      input  lowLaneWriteN, highLaneWriteN, xferGrantN,
      output devRdata, waitN, xferRequestN, irqN
   );
   modport host
   (
      output hostAddr, hostWdata, memorySelectN, registerSelectN, readN,
      output lowLaneWriteN, highLaneWriteN, xferGrantN,
      input  devRdata, waitN, xferRequestN, irqN
   );
endinterface
`default_nettype wire

// *** rtl/hbd_host.sv ***
`include "hbd_cfg.svh"
`default_nettype none
module hbd_host
   import hbd_pkg::*;
(
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          nrst,
   input  wire logic          clkEn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Host bus
   hbd_bus_if.host            bus
);
   ////////////////////////////////////////////////////////////////////////////
   hbd_host_state_type state_ff;
   logic [31:0] ctrl_ff;
   logic [21:0] addr_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic        busy_ff;
   logic        memSelN_ff;
   logic        regSelN_ff;
   logic        rdN_ff;
   logic        loN_ff;
   logic        hiN_ff;
   logic        grantN_ff;
   logic        apbWr;
   logic        apbRd;
   // ctrl: 0 go, 1 read, 2 register, 3 low lane, 4 high lane, 5 grant mode
   assign apbWr = psel && penable && pwrite && !pready;
   assign apbRd = psel && penable && !pwrite && !pready;
   ////////////////////////////////////////////////////////////////////////////
   // APB slave answers one cycle into the access phase
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         prdata   <= 32'h0;
         ctrl_ff  <= 32'h0;
         addr_ff  <= 22'h0;
         wdata_ff <= 16'h0;
      end
      else if (clkEn)
      begin
         pready  <= apbWr || apbRd;
         pslverr <= 1'b0;
         if (state_ff == HBS_REL)
            ctrl_ff[0] <= 1'b0;
         if (apbWr)
         begin
            unique case (paddr)
               `HBD_APB_CTRL:  ctrl_ff  <= pwdata;
               `HBD_APB_ADDR:  addr_ff  <= pwdata[21:0];
               `HBD_APB_WDATA: wdata_ff <= pwdata[15:0];
               default:        pslverr  <= !(paddr == `HBD_APB_STAT
                                           || paddr == `HBD_APB_RDATA);
            endcase
         end
         if (apbRd)
         begin
            unique case (paddr)
               `HBD_APB_CTRL:  prdata <= ctrl_ff;
               `HBD_APB_ADDR:  prdata <= {10'h0, addr_ff};
               `HBD_APB_WDATA: prdata <= {16'h0, wdata_ff};
               `HBD_APB_RDATA: prdata <= {16'h0, rdata_ff};
               `HBD_APB_STAT:  prdata <= {29'h0, !bus.irqN, !bus.xferRequestN,
                                          busy_ff};
               default:
               begin
                  prdata  <= 32'h0;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle: strobe, hold until wait drops, then release
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff   <= HBS_IDLE;
         busy_ff    <= 1'b0;
         rdata_ff   <= 16'h0;
         memSelN_ff <= 1'b1;
         regSelN_ff <= 1'b1;
         rdN_ff     <= 1'b1;
         loN_ff     <= 1'b1;
         hiN_ff     <= 1'b1;
         grantN_ff  <= 1'b1;
      end
      else if (clkEn)
      begin
         unique case (state_ff)
            HBS_IDLE:
            begin
               if (ctrl_ff[0] && (!ctrl_ff[5] || !bus.xferRequestN))
               begin
                  state_ff   <= HBS_STRB;
                  busy_ff    <= 1'b1;
                  grantN_ff  <= !ctrl_ff[5];
                  // Only one select per access; grant replaces memory select
                  memSelN_ff <= ctrl_ff[2] || ctrl_ff[5];
                  regSelN_ff <= !ctrl_ff[2] || ctrl_ff[5];
                  rdN_ff     <= !ctrl_ff[1];
                  loN_ff     <= ctrl_ff[1] || !(ctrl_ff[3] || ctrl_ff[2]);
                  hiN_ff     <= ctrl_ff[1] || !(ctrl_ff[4] || ctrl_ff[2]);
               end
            end
            HBS_STRB:
               state_ff <= HBS_WAIT;
            HBS_WAIT:
            begin
               if (bus.waitN)
               begin
                  state_ff   <= HBS_REL;
                  rdata_ff   <= bus.devRdata;
                  memSelN_ff <= 1'b1;
                  regSelN_ff <= 1'b1;
                  rdN_ff     <= 1'b1;
                  loN_ff     <= 1'b1;
                  hiN_ff     <= 1'b1;
                  grantN_ff  <= 1'b1;
               end
            end
            HBS_REL:
            begin
               state_ff <= HBS_IDLE;
               busy_ff  <= 1'b0;
            end
         endcase
      end
   end
   assign bus.hostAddr        = addr_ff[21:1];
   assign bus.hostWdata       = wdata_ff;
   assign bus.memorySelectN   = memSelN_ff;
   assign bus.registerSelectN = regSelN_ff;
   assign bus.readN           = rdN_ff;
   assign bus.lowLaneWriteN   = loN_ff;
   assign bus.highLaneWriteN  = hiN_ff;
   assign bus.xferGrantN      = grantN_ff;
endmodule
`default_nettype wire

// *** verif/hbd_bus_checker.sv ***
`default_nettype none
module hbd_bus_checker
(
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        nrst,
   // Bus lines
   input wire logic        memorySelectN,
   input wire logic        registerSelectN,
   input wire logic        readN,
   input wire logic        lowLaneWriteN,
   input wire logic        highLaneWriteN,
   input wire logic        xferGrantN,
   input wire logic        waitN,
   input wire logic        xferRequestN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic strb;
   logic acc;
   logic sawWait_ff;
   assign strb = !readN || !lowLaneWriteN || !highLaneWriteN;
   assign acc  = strb && (!memorySelectN || !registerSelectN || !xferGrantN);
   ////////////////////////////////////////////////////////////
   // Stall seen in this access; cleared between accesses
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         sawWait_ff <= 1'b0;
      else if (!acc)
         sawWait_ff <= 1'b0;
      else if (!waitN)
         sawWait_ff <= 1'b1;
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   AST_SEL_EXCL:
   assert property (memorySelectN || registerSelectN)
      else $error("both selects low");
   AST_READ_WORD:
   assert property (!readN |-> lowLaneWriteN && highLaneWriteN)
      else $error("read with write strobe");
   AST_WAIT_WITHIN:
   assert property ($rose(acc) |-> ##[1:3] !waitN)
      else $error("no stall within three cycles");
   AST_WAIT_CAUSE:
   assert property ($fell(waitN) |-> $past(acc))
      else $error("stall without access");
   AST_WAIT_SEEN:
   assert property ($fell(acc) |-> sawWait_ff)
      else $error("access ended without stall");
   AST_HOLD_IN_WAIT:
   assert property (acc && !waitN |=> acc)
      else $error("strobes dropped during stall");
   AST_WAIT_ENDS:
   assert property (!waitN |-> ##[1:6] waitN)
      else $error("stall too long");
   AST_GRANT_AFTER_REQ:
   assert property ($fell(xferGrantN) |-> !$past(xferRequestN))
      else $error("grant without request");
endmodule
`default_nettype wire

// *** verif/host_bus_dma_write_port_tb.sv ***
`include "hbd_cfg.svh"
`default_nettype none
module host_bus_dma_write_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk;
   logic        nrst;
   logic        clkEn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  irqSrc;
   logic        gmWrValid;
   logic [21:0] gmWrAddr;
   logic [15:0] gmWrData;
   logic [1:0]  gmWrLanes;
   logic [21:0] gmAddr;
   logic [15:0] gmData;
   logic [1:0]  gmLanes;
   logic [31:0] rd;
   logic        err;
   int          gmCnt = 0;
   int          base;
   int          nFail = 0;
   int          checks = 0;
   logic [3:0]  dmaCtl [3] = '{{2'h0, `HBD_MODE_MEM}, {2'h1, `HBD_MODE_MEM},
                               {`HBD_AMODE_DUAL, `HBD_MODE_IMG}};
   ////////////////////////////////////////////////////////////
   hbd_bus_if bus ();
   hbd_host hbd_host_inst
   (
      .core_clk (core_clk), .nrst (nrst), .clkEn (clkEn), .psel (psel),
      .penable (penable), .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata),
      .prdata (prdata), .pready (pready), .pslverr (pslverr), .bus (bus)
   );
   hbd_device hbd_device_inst
   (
      .core_clk (core_clk), .nrst (nrst), .clkEn (clkEn), .bus (bus),
      .irqSrc (irqSrc), .gmWrValid (gmWrValid), .gmWrAddr (gmWrAddr),
      .gmWrData (gmWrData), .gmWrLanes (gmWrLanes)
   );
   hbd_bus_checker hbd_bus_checker_inst
   (
      .core_clk (core_clk), .nrst (nrst), .memorySelectN (bus.memorySelectN),
      .registerSelectN (bus.registerSelectN), .readN (bus.readN),
      .lowLaneWriteN (bus.lowLaneWriteN), .highLaneWriteN (bus.highLaneWriteN),
      .xferGrantN (bus.xferGrantN), .waitN (bus.waitN), .xferRequestN (bus.xferRequestN)
   );
   ////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // Records the last memory write of the stream
   always @(posedge core_clk)
   begin
      if (gmWrValid === 1'b1)
      begin
         gmCnt++;
         gmAddr = gmWrAddr;
         gmData = gmWrData;
         gmLanes = gmWrLanes;
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic stuck(input string what);
      $display("CHECK FAILED %s expected completion seen timeout", what);
      nFail++;
      close_out();
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         nFail++;
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         stuck("pready");
   endtask
   // Ctrl codes: 19 word write, 09/11 lane writes, 03 read, 1D/07 register, 39 grant
   task automatic hb(input logic [31:0] ctl, input logic [31:0] adr, input logic [31:0] wd,
                     output logic [31:0] q);
      int n;
      logic e;
      apb(1'b1, `HBD_APB_ADDR, adr, q, e);
      apb(1'b1, `HBD_APB_WDATA, wd, q, e);
      apb(1'b1, `HBD_APB_CTRL, ctl, q, e);
      n = 0;
      do
      begin
         apb(1'b0, `HBD_APB_STAT, 32'h0, q, e);
         n++;
      end
      while (q[0] !== 1'b0 && n < 40);
      if (n >= 40)
         stuck("busy");
      apb(1'b0, `HBD_APB_RDATA, 32'h0, q, e);
   endtask
   task automatic reg_wr(input logic [9:0] idx, input logic [15:0] d);
      logic [31:0] q;
      hb(32'h1D, {21'h0, idx, 1'b0}, {16'h0, d}, q);
   endtask
   task automatic reg_rd(input logic [9:0] idx, output logic [31:0] q);
      hb(32'h07, {21'h0, idx, 1'b0}, 32'h0, q);
   endtask
   task automatic wait_req();
      int n;
      n = 0;
      while (bus.xferRequestN !== 1'b0 && n < 20)
      begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20)
         stuck("xferRequestN");
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      nrst = 1'b0;
      clkEn = 1'b1;
      irqSrc = 2'h0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      chk("waitN", 32'(bus.waitN), 32'h1);
      chk("xferRequestN", 32'(bus.xferRequestN), 32'h1);
      chk("irqN", 32'(bus.irqN), 32'h1);
      hb(32'h19, 32'h10, 32'h1234, rd);
      chk("gmAddr", 32'(gmAddr), 32'h10);
      chk("gmData", 32'(gmData), 32'h1234);
      chk("gmLanes", 32'(gmLanes), 32'h3);
      hb(32'h09, 32'h10, 32'h00AB, rd);
      chk("gmLanes", 32'(gmLanes), 32'h1);
      hb(32'h11, 32'h10, 32'hCD00, rd);
      chk("gmLanes", 32'(gmLanes), 32'h2);
      hb(32'h03, 32'h10, 32'h0, rd);
      chk("memRead", rd & 32'hFFFF, 32'hCDAB);
      chk("gmCnt", gmCnt, 3);
      reg_wr(`HBD_REG_IRQEN, 16'h0001);
      reg_rd(`HBD_REG_IRQEN, rd);
      chk("irqEnable", rd & 32'hFFFF, 32'h1);
      apb(1'b1, 12'h020, 32'h0, rd, err);
      chk("pslverr", 32'(err), 32'h1);
      // Disabled source latches status but must not raise the interrupt line
      irqSrc <= 2'h2;
      @(posedge core_clk);
      irqSrc <= 2'h0;
      reg_rd(`HBD_REG_IRQSTS, rd);
      chk("irqStatus", 32'(rd[1]), 32'h1);
      chk("irqN", 32'(bus.irqN), 32'h1);
      // Memory target twice (both single timings), then image entry in dual timing
      for (int i = 0; i < 3; i++)
      begin
         reg_wr(`HBD_REG_CONV, (i < 2) ? 16'(`HBD_FMT_PLAIN) : 16'h1);
         reg_wr(`HBD_REG_XSTART, 16'h0040);
         reg_wr(`HBD_REG_XCOUNT, 16'h0002);
         reg_wr(`HBD_REG_XCTRL, 16'(dmaCtl[i]));
         wait_req();
         base = gmCnt;
         for (int k = 0; k < 2; k++)
         begin
            hb(32'h39, 32'h3FE, 32'h5A00 + k, rd);
            if (i < 2)
            begin
               chk("xferAddr", 32'(gmAddr), 32'h40 + 2 * k);
               chk("xferData", 32'(gmData), 32'h5A00 + k);
            end
         end
         chk("xferWords", gmCnt - base, (i < 2) ? 2 : 0);
         chk("xferRequestN", 32'(bus.xferRequestN), 32'h1);
         reg_rd(`HBD_REG_STATUS, rd);
         chk("finished", 32'(rd[0]), 32'h1);
         chk("irqN", 32'(bus.irqN), 32'h0);
         reg_rd(`HBD_REG_IRQSTS, rd);
         chk("irqStatus", 32'(rd[0]), 32'h1);
         chk("irqN", 32'(bus.irqN), 32'h1);
      end
      reg_rd(`HBD_REG_IMAGE, rd);
      chk("imageEntry", rd & 32'hFFFF, 32'h5A01);
      close_out();
   end
endmodule
`default_nettype wire
